/* verilog/vir_pkg.sv */
// Purpose: constants for the video input port router
// Assumes: 8-bit register port, 10-bit pixel buses, one 50 MHz clock
// Notes:
// Contract
// - input mode resets to 011, simultaneous SD and progressive scan
// - mode 000 is SD only; muxed stream from S or Y by bus select
// - SD 16/20-bit: select 0 gives luma S, CrCb Y; 1 gives luma Y, CrCb C
// - 8-bit SD samples sit on S bus lines 9 to 2, lowest two unused
// - mode 001 is progressive scan only, mode 010 is HD only
// - 4:2:2 takes Y and CrCb from Y, C; 4:4:4 adds Cr from S
// - RGB only as 4:4:4 in single HD modes; G from Y, R S, B C
// - simultaneous modes are codes 011, 101 and 110
// - simultaneous modes use 4:2:2; HD luma from Y, CrCb from C
// - interleaved progressive data uses Y bus, captured on both clock edges
// - optional active-low sync strobes, SD and HD sets on own pins
package vir_pkg;
   // ****************************************
   // register offsets and reset values
   // ****************************************
   localparam logic [7:0] ADDR_MODE = 8'h01;
   localparam logic [7:0] ADDR_TIMING = 8'h10;
   localparam logic [7:0] ADDR_HD_CFG = 8'h13;
   localparam logic [7:0] ADDR_HD_RGB = 8'h15;
   localparam logic [7:0] ADDR_SD_CFG = 8'h48;
   localparam logic [7:0] ADDR_STATUS = 8'hf0;
   localparam logic [7:0] RST_MODE = 8'h30;
   localparam logic [7:0] RST_ZERO = 8'h00;

   // ****************************************
   // field positions
   // ****************************************
   localparam int MODE_BUS_SEL = 7;
   localparam int MODE_CODE_HI = 6;
   localparam int MODE_CODE_LO = 4;
   localparam int MODE_EXT_SYNC = 2;
   localparam int MODE_DUAL_EDGE = 1;
   localparam int TIMING_ASYNC_HI = 3;
   localparam int TIMING_ASYNC_LO = 2;
   localparam int HD_CFG_422 = 6;
   localparam int HD_CFG_10B = 2;
   localparam int HD_RGB_EN = 1;
   localparam int SD_CFG_10B = 4;
   localparam int SD_CFG_16B = 3;
   localparam int STAT_FMT_ERR = 7;
   localparam int STAT_SD_LOCK = 6;
   localparam int STAT_HD_LOCK = 5;

   // ****************************************
   // input modes and pixel words
   // ****************************************
   typedef enum logic [2:0] {
      VIR_SD_ONLY = 3'b000,
      VIR_PS_ONLY = 3'b001,
      VIR_HD_ONLY = 3'b010,
      VIR_SD_PS = 3'b011,
      VIR_PS_DDR = 3'b100,
      VIR_SD_HD_SDOVR = 3'b101,
      VIR_SD_HD_HDOVR = 3'b110,
      VIR_PS_54 = 3'b111
   } vir_mode_t;

   localparam int PIX_W = 10;
   localparam logic [9:0] LSB2_MASK = 10'h3fc;
   localparam logic [9:0] TRS_ONES = 10'h3ff;
   localparam logic [9:0] TRS_ZERO = 10'h000;
   localparam int TRS_F_BIT = 8;
   localparam int TRS_V_BIT = 7;
   localparam int TRS_H_BIT = 6;
   localparam logic [1:0] TRS_WAIT_XYZ = 2'h3;
endpackage

/* verilog/vir_sync.sv */
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to i_ref_clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
`default_nettype none
module vir_sync #(
   parameter int W = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] q;
   } vir_sync_st_t;

   vir_sync_st_t s;
   vir_sync_st_t next_s;

   always_comb
   begin
      next_s.meta = i_d;
      next_s.q = s.meta;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_q = s.q;
endmodule
`default_nettype wire

/* verilog/vir_trs.sv */
// Purpose: embedded timing reference decoder for one 10-bit stream
// Assumes: one word per i_valid pulse
// Notes: outputs are levels, updated on each reference word
`timescale 1ns/1ns
`default_nettype none
module vir_trs (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic i_valid,
   input wire logic [9:0] i_word,
   output logic o_field,
   output logic o_vblank,
   output logic o_hblank,
   output logic o_locked
);
   typedef struct packed {
      logic [1:0] hits;
      logic field;
      logic vblank;
      logic hblank;
      logic locked;
   } vir_trs_st_t;

   vir_trs_st_t s;
   vir_trs_st_t next_s;

   // ****************************************
   // preamble 3ff 000 000 then status word
   // ****************************************
   always_comb
   begin
      next_s = s;
      if (i_valid)
      begin
         if (s.hits == vir_pkg::TRS_WAIT_XYZ)
         begin
            next_s.field = i_word[vir_pkg::TRS_F_BIT];
            next_s.vblank = i_word[vir_pkg::TRS_V_BIT];
            next_s.hblank = i_word[vir_pkg::TRS_H_BIT];
            next_s.locked = 1'b1;
            next_s.hits = 2'h0;
         end
         else if (i_word == vir_pkg::TRS_ONES)
            next_s.hits = 2'h1;
         else if (i_word == vir_pkg::TRS_ZERO && s.hits != 2'h0)
            next_s.hits = s.hits + 2'h1;
         else
            next_s.hits = 2'h0;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
         s <= '0;
      else
         s <= next_s;
   end

   assign o_field = s.field;
   assign o_vblank = s.vblank;
   assign o_hblank = s.hblank;
   assign o_locked = s.locked;
endmodule
`default_nettype wire

/* verilog/vir_port.sv */
// Purpose: video input port router, routes S/Y/C pixel buses by mode
// Assumes: pixel clocks well below half of i_ref_clk, sampled as data
// Notes: register port answers reads one cycle later, never stalls
`timescale 1ns/1ns
`default_nettype none
module vir_port (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rd_data,
   input wire logic i_primary_pixel_clock_in,
   input wire logic i_secondary_pixel_clock_in,
   input wire logic [9:0] i_sd_pixel_bus,
   input wire logic [9:0] i_luma_pixel_bus,
   input wire logic [9:0] i_chroma_pixel_bus,
   input wire logic i_sd_vsync_b,
   input wire logic i_sd_hsync_b,
   input wire logic i_sd_blank_b,
   input wire logic i_hd_vsync_b,
   input wire logic i_hd_hsync_b,
   input wire logic i_hd_blank_b,
   output logic [9:0] o_sd_luma,
   output logic [9:0] o_sd_chroma,
   output logic o_sd_valid,
   output logic [9:0] o_hd_luma,
   output logic [9:0] o_hd_cb,
   output logic [9:0] o_hd_cr,
   output logic o_hd_valid,
   output logic o_hd_rgb,
   output logic o_sd_vsync,
   output logic o_sd_hsync,
   output logic o_sd_blank,
   output logic o_hd_vsync,
   output logic o_hd_hsync,
   output logic o_hd_blank,
   output logic [1:0] o_async_timing
);
   typedef struct packed {
      logic [7:0] mode_reg;
      logic [1:0] async_sel;
      logic hd_422;
      logic hd_10b;
      logic rgb_en;
      logic sd_10b;
      logic sd_16b;
      logic pclk_a_d;
      logic pclk_b_d;
      logic [7:0] rdata;
      logic [9:0] sd_y;
      logic [9:0] sd_c;
      logic sd_valid;
      logic [9:0] hd_y;
      logic [9:0] hd_cb;
      logic [9:0] hd_cr;
      logic hd_valid;
      logic hd_rgb;
      logic fmt_err;
      logic [2:0] sd_sync;
      logic [2:0] hd_sync;
   } vir_port_st_t;

   vir_port_st_t s;
   vir_port_st_t next_s;

   // ****************************************
   // pin synchronisers
   // ****************************************
   localparam int PIN_W = 38;
   logic [PIN_W-1:0] pins_q;
   logic pclk_a;
   logic pclk_b;
   logic [9:0] bus_s;
   logic [9:0] bus_y;
   logic [9:0] bus_c;
   logic [2:0] sd_sync_b;
   logic [2:0] hd_sync_b;

   // clocks and data share latency so a detected edge sees matching data
   vir_sync #(
      .W(PIN_W)
   ) u_pins (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_d({i_primary_pixel_clock_in, i_secondary_pixel_clock_in,
            i_sd_pixel_bus, i_luma_pixel_bus, i_chroma_pixel_bus,
            i_sd_vsync_b, i_sd_hsync_b, i_sd_blank_b,
            i_hd_vsync_b, i_hd_hsync_b, i_hd_blank_b}),
      .o_q(pins_q)
   );

   assign {pclk_a, pclk_b, bus_s, bus_y, bus_c, sd_sync_b, hd_sync_b} = pins_q;

   // ****************************************
   // embedded timing decoders
   // ****************************************
   logic sd_f;
   logic sd_v;
   logic sd_h;
   logic sd_lock;
   logic hd_v;
   logic hd_h;
   logic hd_lock;

   vir_trs u_sd_trs (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_valid(s.sd_valid),
      .i_word(s.sd_y),
      .o_field(sd_f),
      .o_vblank(sd_v),
      .o_hblank(sd_h),
      .o_locked(sd_lock)
   );

   vir_trs u_hd_trs (
      .i_ref_clk(i_ref_clk),
      .i_rst_b(i_rst_b),
      .i_valid(s.hd_valid),
      .i_word(s.hd_y),
      .o_field(),
      .o_vblank(hd_v),
      .o_hblank(hd_h),
      .o_locked(hd_lock)
   );

   // ****************************************
   // mode decode
   // ****************************************
   vir_pkg::vir_mode_t mode;
   logic bus_sel;
   logic ext_sync;
   logic dual_edge;
   logic sd_act;
   logic hd_act;
   logic simul;
   logic single_hd;
   logic hd_clk_b;
   logic sd_rise;
   logic hd_edge;
   logic hd_444;
   logic [9:0] sd_mask;
   logic [9:0] hd_mask;

   always_comb
   begin
      mode = vir_pkg::vir_mode_t'(s.mode_reg[vir_pkg::MODE_CODE_HI:vir_pkg::MODE_CODE_LO]);
      bus_sel = s.mode_reg[vir_pkg::MODE_BUS_SEL];
      ext_sync = s.mode_reg[vir_pkg::MODE_EXT_SYNC];
      dual_edge = s.mode_reg[vir_pkg::MODE_DUAL_EDGE];
      simul = (mode == vir_pkg::VIR_SD_PS) || (mode == vir_pkg::VIR_SD_HD_SDOVR)
         || (mode == vir_pkg::VIR_SD_HD_HDOVR);
      single_hd = (mode == vir_pkg::VIR_PS_ONLY) || (mode == vir_pkg::VIR_HD_ONLY);
      sd_act = simul || (mode == vir_pkg::VIR_SD_ONLY);
      hd_act = !(mode == vir_pkg::VIR_SD_ONLY);
      hd_clk_b = simul;
      sd_rise = pclk_a && !s.pclk_a_d;
      if (hd_clk_b)
         hd_edge = (pclk_b != s.pclk_b_d) && (dual_edge || pclk_b);
      else
         hd_edge = (pclk_a != s.pclk_a_d) && (dual_edge || pclk_a);
      hd_444 = !s.hd_422 && !simul;
      sd_mask = s.sd_10b ? 10'h3ff : vir_pkg::LSB2_MASK;
      hd_mask = s.hd_10b ? 10'h3ff : vir_pkg::LSB2_MASK;
   end

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_s = s;
      next_s.pclk_a_d = pclk_a;
      next_s.pclk_b_d = pclk_b;
      next_s.sd_valid = 1'b0;
      next_s.hd_valid = 1'b0;
      next_s.rdata = 8'h00;

      // register writes
      if (i_wr)
      begin
         case (i_addr)
            vir_pkg::ADDR_MODE: next_s.mode_reg = i_wr_data;
            vir_pkg::ADDR_TIMING:
               next_s.async_sel = i_wr_data[vir_pkg::TIMING_ASYNC_HI:vir_pkg::TIMING_ASYNC_LO];
            vir_pkg::ADDR_HD_CFG:
            begin
               next_s.hd_422 = i_wr_data[vir_pkg::HD_CFG_422];
               next_s.hd_10b = i_wr_data[vir_pkg::HD_CFG_10B];
            end
            vir_pkg::ADDR_HD_RGB: next_s.rgb_en = i_wr_data[vir_pkg::HD_RGB_EN];
            vir_pkg::ADDR_SD_CFG:
            begin
               next_s.sd_10b = i_wr_data[vir_pkg::SD_CFG_10B];
               next_s.sd_16b = i_wr_data[vir_pkg::SD_CFG_16B];
            end
            default: next_s.mode_reg = s.mode_reg;
         endcase
      end

      // register reads, unmapped reads return zero
      if (i_rd)
      begin
         case (i_addr)
            vir_pkg::ADDR_MODE: next_s.rdata = s.mode_reg;
            vir_pkg::ADDR_TIMING:
               next_s.rdata[vir_pkg::TIMING_ASYNC_HI:vir_pkg::TIMING_ASYNC_LO] = s.async_sel;
            vir_pkg::ADDR_HD_CFG:
            begin
               next_s.rdata[vir_pkg::HD_CFG_422] = s.hd_422;
               next_s.rdata[vir_pkg::HD_CFG_10B] = s.hd_10b;
            end
            vir_pkg::ADDR_HD_RGB: next_s.rdata[vir_pkg::HD_RGB_EN] = s.rgb_en;
            vir_pkg::ADDR_SD_CFG:
            begin
               next_s.rdata[vir_pkg::SD_CFG_10B] = s.sd_10b;
               next_s.rdata[vir_pkg::SD_CFG_16B] = s.sd_16b;
            end
            vir_pkg::ADDR_STATUS:
            begin
               next_s.rdata[vir_pkg::STAT_FMT_ERR] = s.fmt_err;
               next_s.rdata[vir_pkg::STAT_SD_LOCK] = sd_lock;
               next_s.rdata[vir_pkg::STAT_HD_LOCK] = hd_lock;
               next_s.rdata[2:0] = mode;
            end
            default: next_s.rdata = 8'h00;
         endcase
      end

      // SD capture on primary clock rising edge
      if (sd_act && sd_rise)
      begin
         next_s.sd_valid = 1'b1;
         if (simul)
         begin
            next_s.sd_y = bus_s & sd_mask;
            next_s.sd_c = 10'h000;
         end
         else if (s.sd_16b)
         begin
            next_s.sd_y = (bus_sel ? bus_y : bus_s) & sd_mask;
            next_s.sd_c = (bus_sel ? bus_c : bus_y) & sd_mask;
         end
         else
         begin
            next_s.sd_y = (bus_sel ? bus_y : bus_s) & sd_mask;
            next_s.sd_c = 10'h000;
         end
      end

      // HD / progressive scan capture
      if (hd_act && hd_edge)
      begin
         next_s.hd_valid = 1'b1;
         next_s.hd_y = bus_y & hd_mask;
         if (dual_edge)
         begin
            // single interleaved bus: chroma words arrive on Y
            next_s.hd_cb = 10'h000;
            next_s.hd_cr = 10'h000;
         end
         else
         begin
            next_s.hd_cb = bus_c & hd_mask;
            next_s.hd_cr = hd_444 ? (bus_s & hd_mask) : 10'h000;
         end
      end

      // RGB only accepted as 4:4:4 in single HD modes
      next_s.hd_rgb = s.rgb_en && hd_444 && single_hd;
      next_s.fmt_err = s.rgb_en && hd_act && !(hd_444 && single_hd);

      // sync strobes: pins are active low, outputs active high
      if (ext_sync)
      begin
         next_s.sd_sync = ~sd_sync_b;
         next_s.hd_sync = ~hd_sync_b;
      end
      else
      begin
         next_s.sd_sync = {sd_v, sd_h, sd_v | sd_h};
         next_s.hd_sync = {hd_v, hd_h, hd_v | hd_h};
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
   begin
      if (!i_rst_b)
      begin
         s <= '0;
         s.mode_reg <= vir_pkg::RST_MODE;
      end
      else
         s <= next_s;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_rd_data = s.rdata;
   assign o_sd_luma = s.sd_y;
   assign o_sd_chroma = s.sd_c;
   assign o_sd_valid = s.sd_valid;
   assign o_hd_luma = s.hd_y;
   assign o_hd_cb = s.hd_cb;
   assign o_hd_cr = s.hd_cr;
   assign o_hd_valid = s.hd_valid;
   assign o_hd_rgb = s.hd_rgb;
   assign {o_sd_vsync, o_sd_hsync, o_sd_blank} = s.sd_sync;
   assign {o_hd_vsync, o_hd_hsync, o_hd_blank} = s.hd_sync;
   // async timing selection is carried to the timing generator downstream
   assign o_async_timing = s.async_sel;
endmodule
`default_nettype wire

/* dv/vir_port_properties.sv */
// Purpose: concurrent checks on the router's register port and capture timing
// Assumes: bound to vir_port, one clock domain
// Notes: keeps its own copy of the mode register, seen from the write strobe
`timescale 1ns/1ns
`default_nettype none
module vir_port_properties (
   input wire logic i_ref_clk,
   input wire logic i_rst_b,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rd_data,
   input wire logic i_primary_pixel_clock_in,
   input wire logic i_secondary_pixel_clock_in,
   input wire logic i_sd_vsync_b,
   input wire logic i_hd_hsync_b,
   input wire logic o_sd_valid,
   input wire logic o_hd_valid,
   input wire logic o_sd_vsync,
   input wire logic o_hd_hsync
);
   logic [7:0] mode_q;
   logic sim_on;
   logic sd_on;
   default clocking dc @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_b);

   always_ff @(posedge i_ref_clk or negedge i_rst_b)
      if (!i_rst_b)
         mode_q <= 8'h30;
      else if (i_wr && i_addr == vir_pkg::ADDR_MODE)
         mode_q <= i_wr_data;
   assign sim_on = mode_q[6:4] inside {3'h3, 3'h5, 3'h6};
   assign sd_on = sim_on || mode_q[6:4] == 3'h0;

   // ****************************************
   // properties
   // ****************************************
   property p_rd_idle;
      !$past(i_rd) |-> o_rd_data == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   property p_mode_rd;
      i_rd && i_addr == vir_pkg::ADDR_MODE |=> o_rd_data == ($past(mode_q) & 8'hf6);
   endproperty
   a_mode_rd: assert property (p_mode_rd) else $error("mode readback wrong");
   property p_sd_off;
      o_sd_valid |-> sd_on;
   endproperty
   a_sd_off: assert property (p_sd_off) else $error("sd word in single hd mode");
   property p_hd_off;
      o_hd_valid |-> mode_q[6:4] != 3'h0;
   endproperty
   a_hd_off: assert property (p_hd_off) else $error("hd word in sd mode");
   property p_sd_lat;
      $rose(i_primary_pixel_clock_in) && sd_on |-> ##[2:5] o_sd_valid;
   endproperty
   a_sd_lat: assert property (p_sd_lat) else $error("sd edge not captured");
   property p_hd_lat;
      $rose(i_secondary_pixel_clock_in) && sim_on |-> ##[2:5] o_hd_valid;
   endproperty
   a_hd_lat: assert property (p_hd_lat) else $error("hd edge not captured");
   property p_sd_sync;
      mode_q[2] && $past(mode_q[2], 4) |-> o_sd_vsync == !$past(i_sd_vsync_b, 3);
   endproperty
   a_sd_sync: assert property (p_sd_sync) else $error("sd vsync wrong");
   property p_hd_sync;
      mode_q[2] && $past(mode_q[2], 4) |-> o_hd_hsync == !$past(i_hd_hsync_b, 3);
   endproperty
   a_hd_sync: assert property (p_hd_sync) else $error("hd hsync wrong");
endmodule
`default_nettype wire

/* dv/vir_src_model.sv */
// Purpose: upstream video source driving the router's pixel pins
// Assumes: called from the bench, one word per pixel clock edge
// Notes: pixel clock slowed so the 50 MHz sampler sees each phase
`timescale 1ns/1ns
`default_nettype none
module vir_src_model (
   input wire logic i_ref_clk,
   output logic o_clk_a,
   output logic o_clk_b,
   output logic [9:0] o_sd,
   output logic [9:0] o_luma,
   output logic [9:0] o_chroma,
   output logic [5:0] o_sync_b
);
   initial
   begin
      o_clk_a = 1'b0;
      o_clk_b = 1'b0;
      o_sd = 10'h000;
      o_luma = 10'h000;
      o_chroma = 10'h000;
      o_sync_b = 6'h3f;
   end

   // ****************************************
   // word and strobe drivers
   // ****************************************
   task automatic put(input bit on_b, lvl, input logic [9:0] s, y, c, input int slow);
      @(posedge i_ref_clk);
      o_sd <= s;
      o_luma <= y;
      o_chroma <= c;
      repeat (3 + slow) @(posedge i_ref_clk);
      if (on_b)
         o_clk_b <= lvl;
      else
         o_clk_a <= lvl;
      repeat (5) @(posedge i_ref_clk);
      // hold over: stale data would hide a late sample
      o_sd <= ~s;
      o_luma <= ~y;
      o_chroma <= ~c;
   endtask
   task automatic sync(input logic [5:0] v);
      @(posedge i_ref_clk);
      o_sync_b <= v;
   endtask
endmodule
`default_nettype wire

/* dv/vir_port_bench.sv */
// Purpose: self-checking bench for the video input port router
// Assumes: source model on the pins, bench on the register port
// Notes: words are queued at each pixel edge and popped on valid
`timescale 1ns/1ns
`default_nettype none
module vir_port_bench;
   logic i_ref_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [7:0] i_addr = 8'h00;
   logic [7:0] i_wr_data = 8'h00;
   logic i_wr = 1'b0;
   logic i_rd = 1'b0;
   wire logic i_primary_pixel_clock_in, i_secondary_pixel_clock_in;
   wire logic [9:0] i_sd_pixel_bus, i_luma_pixel_bus, i_chroma_pixel_bus;
   wire logic i_sd_vsync_b, i_sd_hsync_b, i_sd_blank_b, i_hd_vsync_b, i_hd_hsync_b, i_hd_blank_b;
   logic [7:0] o_rd_data;
   logic [9:0] o_sd_luma, o_sd_chroma, o_hd_luma, o_hd_cb, o_hd_cr;
   logic o_sd_valid, o_hd_valid, o_hd_rgb, o_sd_vsync, o_sd_hsync, o_sd_blank;
   logic o_hd_vsync, o_hd_hsync, o_hd_blank;
   logic [1:0] o_async_timing;
   logic [29:0] sd_q[$], hd_q[$];
   logic [7:0] rd_q[$];
   logic rd_d = 1'b0;
   logic [7:0] md, sc, hc;
   int num_errors = 0;
   int n_tests = 0;
   logic [5:0] sv;
   // 0x50000000 asks for 4:4:4 in a simultaneous mode, which must still give 4:2:2
   logic [31:0] cfg[13] = '{32'h00100400, 32'h80000000, 32'h00180400, 32'h80080000,
      32'h10104400, 32'h20100402, 32'h20004000, 32'h30104400, 32'h50000000,
      32'h60104400, 32'h32104400, 32'h10100400, 32'h42104400};
   logic [9:0] trs[8] = '{10'h3ff, 10'h000, 10'h000, 10'h280, 10'h3ff, 10'h000, 10'h000, 10'h240};

   vir_port uut (.i_ref_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr, .i_rd, .o_rd_data,
      .i_primary_pixel_clock_in, .i_secondary_pixel_clock_in, .i_sd_pixel_bus,
      .i_luma_pixel_bus, .i_chroma_pixel_bus, .i_sd_vsync_b, .i_sd_hsync_b, .i_sd_blank_b,
      .i_hd_vsync_b, .i_hd_hsync_b, .i_hd_blank_b, .o_sd_luma, .o_sd_chroma, .o_sd_valid,
      .o_hd_luma, .o_hd_cb, .o_hd_cr, .o_hd_valid, .o_hd_rgb, .o_sd_vsync, .o_sd_hsync,
      .o_sd_blank, .o_hd_vsync, .o_hd_hsync, .o_hd_blank, .o_async_timing);
   vir_src_model src (.i_ref_clk, .o_clk_a(i_primary_pixel_clock_in),
      .o_clk_b(i_secondary_pixel_clock_in), .o_sd(i_sd_pixel_bus), .o_luma(i_luma_pixel_bus),
      .o_chroma(i_chroma_pixel_bus), .o_sync_b({i_sd_vsync_b, i_sd_hsync_b, i_sd_blank_b,
      i_hd_vsync_b, i_hd_hsync_b, i_hd_blank_b}));

   always #10 i_ref_clk = ~i_ref_clk;

   // ****************************************
   // tasks
   // ****************************************
   task automatic chk(input string n, input logic [29:0] e, input logic [29:0] g);
      n_tests++;
      if (g !== e)
      begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic report_and_stop;
      if (num_errors == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, e);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      rd_q.push_back(e);
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
   endtask
   task automatic cfg_set(input logic [31:0] v);
      {md, sc, hc} = v[31:8];
      wr(vir_pkg::ADDR_MODE, md);
      wr(vir_pkg::ADDR_SD_CFG, sc);
      wr(vir_pkg::ADDR_HD_CFG, hc);
      wr(vir_pkg::ADDR_HD_RGB, v[7:0]);
      rd(vir_pkg::ADDR_MODE, md & 8'hf6);
      chk("hd_rgb", {29'h0, v[1] && !hc[6] && (md[6:4] inside {3'h1, 3'h2})},
         {29'h0, o_hd_rgb});
   endtask
   task automatic px(input bit on_b, lvl, input logic [9:0] s, y, c);
      logic [9:0] sm, hm, l, k;
      bit sim, sd_m;
      sim = md[6:4] inside {3'h3, 3'h5, 3'h6};
      sd_m = md[6:4] == 3'h0;
      sm = sc[4] ? 10'h3ff : vir_pkg::LSB2_MASK;
      hm = hc[2] ? 10'h3ff : vir_pkg::LSB2_MASK;
      l = (sd_m && md[7]) ? y : s;
      k = (sd_m && sc[3]) ? (md[7] ? c : y) : 10'h000;
      if (!on_b && lvl && (sd_m || sim))
         sd_q.push_back({l & sm, k & sm, 10'h000});
      k = (md[6:4] inside {3'h1, 3'h2} && !hc[6]) ? s : 10'h000;
      l = md[1] ? 10'h000 : c;
      if (on_b == sim && (lvl || md[1]) && !sd_m)
         hd_q.push_back({y & hm, l & hm, k & hm});
      src.put(on_b, lvl, s, y, c, $urandom_range(3));
   endtask

   always @(posedge i_ref_clk)
   begin
      rd_d <= i_rd;
      if (rd_d)
         chk("rd_data", {22'h0, rd_q.pop_front()}, {22'h0, o_rd_data});
      if (o_sd_valid === 1'b1)
         chk("sd_word", sd_q.pop_front(), {o_sd_luma, o_sd_chroma, 10'h000});
      if (o_hd_valid === 1'b1)
         chk("hd_word", hd_q.pop_front(), {o_hd_luma, o_hd_cb, o_hd_cr});
   end

   initial
   begin
      #400000;
      num_errors++;
      report_and_stop();
   end

   initial
   begin
      void'($urandom(58));
      repeat (3) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      rd(vir_pkg::ADDR_MODE, 8'h30);
      wr(vir_pkg::ADDR_STATUS, 8'hff);
      rd(vir_pkg::ADDR_STATUS, 8'h03);
      wr(8'h7b, 8'hff);
      rd(8'h7b, 8'h00);
      wr(vir_pkg::ADDR_TIMING, 8'h0c);
      foreach (cfg[n])
      begin
         cfg_set(cfg[n]);
         for (int i = 0; i < 12; i++)
            px(i[1], !i[0], 10'($urandom), 10'($urandom), 10'($urandom));
      end
      cfg_set(32'h00100400);
      for (int i = 0; i < 8; i++)
      begin
         px(1'b0, 1'b1, trs[i], 10'h155, 10'h0aa);
         px(1'b0, 1'b0, ~trs[i], 10'h000, 10'h000);
         if (i[1:0] == 2'h3)
            chk("trs_sync", {27'h0, i[2] ? 3'b011 : 3'b101}, {27'h0, o_sd_vsync, o_sd_hsync,
               o_sd_blank});
      end
      // strobes change only while no pixel edge is pending
      cfg_set(32'h34100400);
      repeat (12)
      begin
         sv = 6'($urandom);
         src.sync(sv);
         repeat (4) @(posedge i_ref_clk);
         chk("ext_sync", {24'h0, ~sv}, {24'h0, o_sd_vsync, o_sd_hsync, o_sd_blank,
            o_hd_vsync, o_hd_hsync, o_hd_blank});
      end
      chk("async", 30'h3, {28'h0, o_async_timing});
      repeat (20) @(posedge i_ref_clk);
      chk("left", 30'h0, 30'(sd_q.size() + hd_q.size()));
      report_and_stop();
   end
endmodule

bind vir_port vir_port_properties u_props (.i_ref_clk, .i_rst_b, .i_addr, .i_wr_data, .i_wr,
   .i_rd, .o_rd_data, .i_primary_pixel_clock_in, .i_secondary_pixel_clock_in, .i_sd_vsync_b,
   .i_hd_hsync_b, .o_sd_valid, .o_hd_valid, .o_sd_vsync, .o_hd_hsync);
`default_nettype wire
